// *** fars_pkg.sv ***
`default_nettype none
package fars_pkg;
   // clock and timebase
   localparam int CLK_PERIOD_NS = 50;
   localparam int TIMEBASE_NS   = 1000000;            // one timebase tick is 1 ms
   localparam int TICK_CYCLES   = TIMEBASE_NS / CLK_PERIOD_NS;

   // register byte offsets
   localparam logic [4:0] OFS_AR_EN   = 5'h00;
   localparam logic [4:0] OFS_MAX_CNT = 5'h04;
   localparam logic [4:0] OFS_TRIAL   = 5'h08;
   localparam logic [4:0] OFS_DELAY   = 5'h0c;
   localparam logic [4:0] OFS_STATUS  = 5'h10;
   localparam logic [4:0] OFS_IRQ_STS = 5'h14;
   localparam logic [4:0] OFS_IRQ_MSK = 5'h18;
   localparam logic [4:0] OFS_MAN_RST = 5'h1c;

   // fault class bit positions (enable, latch and status layout)
   localparam int CLS_EXCESS   = 0;
   localparam int CLS_BUS_HIGH = 1;
   localparam int CLS_BUS_LOW  = 2;
   localparam int CLS_ANALOG   = 3;
   localparam int CLS_EXT      = 4;
   localparam int NCLS         = 5;

   // interrupt event bit positions
   localparam int IRQ_FAULT = 0;
   localparam int IRQ_AUTO  = 1;
   localparam int IRQ_LOCK  = 2;
   localparam int NIRQ      = 3;

   // status and manual reset register field positions
   localparam int STS_STATE_LSB = 0;
   localparam int STS_COUNT_LSB = 8;
   localparam int STS_LATCH_LSB = 16;
   localparam int STS_LOCK_BIT  = 24;
   localparam int MAN_RST_BIT   = 0;

   // reset values
   localparam logic [4:0]  RST_AR_EN   = 5'h00;
   localparam logic [7:0]  RST_MAX_CNT = 8'h03;
   localparam logic [31:0] RST_TRIAL   = 32'h0000_7530;  // 30000 ms
   localparam logic [15:0] RST_DELAY   = 16'h0bb8;       // 3000 ms
   localparam logic [2:0]  RST_IRQ_MSK = 3'h0;

   typedef enum logic [1:0] {FARS_RUN, FARS_DELAY, FARS_LOCKED, FARS_HELD} fars_state_t;
endpackage
`default_nettype wire

// *** fars_top.sv ***
// Contract
// - count auto resets against maximum in window
// - exceeding maximum locks out, drive stays stopped
// - after lockout only manual reset restarts
// - third reset in window needs maximum three
// - trial time sets the counting window length
// - wait restart delay before clearing the fault
// - zero delay resets at once
// - excess current auto reset enable bit
// - bus high auto reset enable bit
// - bus low auto reset enable bit
// - analog low auto reset enable bit
// - analog restart only once input recovered
// - external input auto reset enable bit
//
// The AHB-Lite slave port and the address map were chosen for this implementation.
`default_nettype none
module fars_top #(
   parameter int TICK_CYCLES = fars_pkg::TICK_CYCLES
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        excess_current_fault,
   input  wire logic        bus_high_fault,
   input  wire logic        bus_low_fault,
   input  wire logic        analog_below_floor_fault,
   input  wire logic        ext_input_fault_a,
   input  wire logic        ext_input_fault_b,
   input  wire logic        reset_source_req,
   output logic             run_enable,
   output logic             fault_reset,
   output logic             lockout,
   output logic             irq
);
   import fars_pkg::*;

   localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

   typedef struct packed {
      fars_state_t      st;
      logic [NCLS-1:0]  latch;
      logic [7:0]       count;
      logic             trial_on;
      logic [31:0]      trial_ms;
      logic [15:0]      delay_ms;
      logic [15:0]      pre;
      logic [NCLS-1:0]  ar_en;
      logic [7:0]       max_cnt;
      logic [31:0]      trial_cfg;
      logic [15:0]      delay_cfg;
      logic [NIRQ-1:0]  irq_sts;
      logic [NIRQ-1:0]  irq_msk;
      logic             ph_wr;
      logic [4:0]       ph_addr;
      logic [31:0]      rdata;
      logic             fault_clr;
   } fars_regs_t;

   fars_regs_t r_reg;
   fars_regs_t r_next;

   logic [NCLS-1:0] raw;
   logic [NCLS-1:0] lat_now;
   logic            ok_now;
   logic            tick;
   logic            man_req;
   logic            auto_fire;
   logic [7:0]      cnt_eff;
   logic [NIRQ-1:0] ev;
   logic [NIRQ-1:0] w1c;
   logic            acc;

   // true when every latched class has its auto reset enabled
   function automatic logic fars_auto_ok(input logic [NCLS-1:0] lat,
                                         input logic [NCLS-1:0] en);
      fars_auto_ok = ((lat & ~en) == '0);
   endfunction

   // fault inputs folded into one bit per class
   function automatic logic [NCLS-1:0] fars_class_vec(input logic oc, input logic bh,
                                                      input logic bl, input logic al,
                                                      input logic ea, input logic eb);
      fars_class_vec = '0;
      fars_class_vec[CLS_EXCESS]   = oc;
      fars_class_vec[CLS_BUS_HIGH] = bh;
      fars_class_vec[CLS_BUS_LOW]  = bl;
      fars_class_vec[CLS_ANALOG]   = al;
      fars_class_vec[CLS_EXT]      = ea | eb;
   endfunction

   // next-state logic: bus slave, timers, supervisor and interrupts
   always_comb
   begin
      r_next    = r_reg;
      r_next.fault_clr = 1'b0;
      ev        = '0;
      w1c       = '0;
      auto_fire = 1'b0;
      raw       = fars_class_vec(excess_current_fault, bus_high_fault, bus_low_fault,
                                 analog_below_floor_fault, ext_input_fault_a,
                                 ext_input_fault_b);
      lat_now   = r_reg.latch | raw;
      r_next.latch = lat_now;
      ok_now    = fars_auto_ok(lat_now, r_reg.ar_en);
      tick      = (r_reg.pre == TICK_LAST);
      r_next.pre = tick ? 16'h0000 : r_reg.pre + 16'h0001;

      // address phase: capture and prepare read data
      acc = hsel & htrans[1] & hready;
      r_next.ph_wr = acc & hwrite;
      r_next.ph_addr = haddr[4:0];
      if (acc && !hwrite)
      begin
         case (haddr[4:0])
            OFS_AR_EN:   r_next.rdata = {27'h0, r_reg.ar_en};
            OFS_MAX_CNT: r_next.rdata = {24'h0, r_reg.max_cnt};
            OFS_TRIAL:   r_next.rdata = r_reg.trial_cfg;
            OFS_DELAY:   r_next.rdata = {16'h0, r_reg.delay_cfg};
            OFS_STATUS:
            begin
               r_next.rdata = 32'h0;
               r_next.rdata[STS_STATE_LSB +: 2] = r_reg.st;
               r_next.rdata[STS_COUNT_LSB +: 8] = r_reg.count;
               r_next.rdata[STS_LATCH_LSB +: NCLS] = r_reg.latch;
               r_next.rdata[STS_LOCK_BIT] = (r_reg.st == FARS_LOCKED);
            end
            OFS_IRQ_STS: r_next.rdata = {29'h0, r_reg.irq_sts};
            OFS_IRQ_MSK: r_next.rdata = {29'h0, r_reg.irq_msk};
            default:     r_next.rdata = 32'h0;
         endcase
      end

      // data phase: register writes
      man_req = reset_source_req;
      if (r_reg.ph_wr)
      begin
         case (r_reg.ph_addr)
            OFS_AR_EN:   r_next.ar_en = hwdata[NCLS-1:0];
            OFS_MAX_CNT: r_next.max_cnt = hwdata[7:0];
            OFS_TRIAL:   r_next.trial_cfg = hwdata;
            OFS_DELAY:   r_next.delay_cfg = hwdata[15:0];
            OFS_IRQ_STS: w1c = hwdata[NIRQ-1:0];
            OFS_IRQ_MSK: r_next.irq_msk = hwdata[NIRQ-1:0];
            OFS_MAN_RST: man_req = reset_source_req | hwdata[MAN_RST_BIT];
            default:     w1c = '0;
         endcase
      end

      // trial window: count expires when the window runs out
      if (r_reg.trial_on && tick)
      begin
         if (r_reg.trial_ms + 32'h0000_0001 >= r_reg.trial_cfg)
         begin
            r_next.trial_on = 1'b0;
            r_next.count = 8'h00;
         end
         else
         begin
            r_next.trial_ms = r_reg.trial_ms + 32'h0000_0001;
         end
      end
      cnt_eff = r_next.count;

      // supervisor sequence
      case (r_reg.st)
         FARS_RUN:
         begin
            if (lat_now != '0)
            begin
               ev[IRQ_FAULT] = 1'b1;
               r_next.delay_ms = 16'h0000;
               if (!ok_now)
               begin
                  r_next.st = FARS_HELD;
               end
               else if (cnt_eff >= r_reg.max_cnt)
               begin
                  r_next.st = FARS_LOCKED;
                  ev[IRQ_LOCK] = 1'b1;
               end
               else if (r_reg.delay_cfg == 16'h0000 && raw == '0)
               begin
                  auto_fire = 1'b1;
               end
               else
               begin
                  r_next.st = FARS_DELAY;
               end
            end
         end
         FARS_DELAY:
         begin
            if (tick && r_reg.delay_ms < r_reg.delay_cfg)
            begin
               r_next.delay_ms = r_reg.delay_ms + 16'h0001;
            end
            if (!ok_now)
            begin
               r_next.st = FARS_HELD;
            end
            else if (r_reg.delay_ms >= r_reg.delay_cfg && raw == '0)
            begin
               auto_fire = 1'b1;
            end
         end
         FARS_LOCKED, FARS_HELD:
         begin
            if (man_req && raw == '0)
            begin
               r_next.latch = '0;
               r_next.count = 8'h00;
               r_next.trial_on = 1'b0;
               r_next.fault_clr = 1'b1;
               r_next.st = FARS_RUN;
            end
         end
         default: r_next.st = FARS_RUN;
      endcase

      // automatic reset: clear faults, count it, open a window if none
      if (auto_fire)
      begin
         r_next.latch = '0;
         r_next.fault_clr = 1'b1;
         r_next.count = cnt_eff + 8'h01;
         r_next.st = FARS_RUN;
         ev[IRQ_AUTO] = 1'b1;
         if (!r_next.trial_on)
         begin
            r_next.trial_on = 1'b1;
            r_next.trial_ms = 32'h0000_0000;
         end
      end

      // sticky events, set wins over write-one-to-clear
      r_next.irq_sts = (r_reg.irq_sts & ~w1c) | ev;
   end

   // state register
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         r_reg <= '{st: FARS_RUN, latch: '0, count: 8'h00, trial_on: 1'b0,
                    trial_ms: 32'h0, delay_ms: 16'h0, pre: 16'h0, ar_en: RST_AR_EN,
                    max_cnt: RST_MAX_CNT, trial_cfg: RST_TRIAL, delay_cfg: RST_DELAY,
                    irq_sts: '0, irq_msk: RST_IRQ_MSK, ph_wr: 1'b0, ph_addr: 5'h00,
                    rdata: 32'h0, fault_clr: 1'b0};
      end
      else
      begin
         r_reg <= r_next;
      end
   end

   // outputs
   assign hrdata      = r_reg.rdata;
   assign hreadyout   = 1'b1;                    // zero wait states
   assign hresp       = 1'b0;                    // always OKAY
   assign run_enable  = (r_reg.st == FARS_RUN);
   assign lockout     = (r_reg.st == FARS_LOCKED);
   assign fault_reset = r_reg.fault_clr;
   assign irq         = |(r_reg.irq_sts & r_reg.irq_msk);

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence s_leave_delay;
      (r_reg.st == FARS_DELAY && auto_fire) ##1 (fault_reset && run_enable);
   endsequence

   sequence s_lock_entry;
      (r_reg.st == FARS_RUN && lat_now != '0 && ok_now && cnt_eff >= r_reg.max_cnt)
      ##1 (lockout && !run_enable);
   endsequence

   a_count_step: assert property (auto_fire |=> r_reg.count == $past(cnt_eff) + 8'h01)
      else $error("auto reset not counted");
   a_lock_entry: assert property ((r_reg.st == FARS_RUN && lat_now != '0 && ok_now
                                   && cnt_eff >= r_reg.max_cnt) |-> s_lock_entry)
      else $error("lockout not entered");
   a_lock_hold: assert property ((lockout && !(man_req && raw == '0)) |=> lockout)
      else $error("lockout left without manual reset");
   a_third_gate: assert property (auto_fire |-> cnt_eff < r_reg.max_cnt)
      else $error("auto reset beyond maximum");
   a_trial_expire: assert property ((r_reg.trial_on && tick && !auto_fire
                                     && r_reg.trial_ms + 32'h0000_0001 >= r_reg.trial_cfg)
                                    |=> (r_reg.count == 8'h00 && !r_reg.trial_on))
      else $error("trial window did not expire");
   a_delay_wait: assert property ((r_reg.st == FARS_DELAY && auto_fire)
                                  |-> (r_reg.delay_ms >= r_reg.delay_cfg) and s_leave_delay)
      else $error("restart before delay");
   // with no delay set, the reset follows the first cycle with all inputs low
   a_zero_delay: assert property ((r_reg.st == FARS_DELAY && ok_now && raw == '0
                                   && r_reg.delay_cfg == 16'h0000)
                                  |=> (fault_reset && run_enable))
      else $error("zero delay reset not immediate");
   a_class_gate: assert property (auto_fire |-> ((lat_now & ~r_reg.ar_en) == '0))
      else $error("auto reset of disabled class");
   a_input_clear: assert property (auto_fire |-> raw == '0)
      else $error("restart while fault input active");
   a_held_latch: assert property ((r_reg.st == FARS_HELD && !(man_req && raw == '0))
                                  |=> (r_reg.st == FARS_HELD && !fault_reset))
      else $error("disabled class fault released");

endmodule // fars_top
`default_nettype wire

// *** test_fars_top.sv ***
`default_nettype none
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin err_total++; $display("[ERR] %s exp %h got %h", nm, e, s); end end
module test_fars_top;
   timeunit 1ns;
   timeprecision 1ns;
   import fars_pkg::*;
   localparam int TK = 4;               // short timebase tick for simulation
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, exp_w;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        run_enable, fault_reset, lockout, irq, reset_source_req;
   logic [5:0]  fin;                    // excess, high, low, analog, ext a, ext b
   logic        rd_dp, pin_dp;
   logic [31:0] rq[$];
   logic [31:0] pq[$];
   int          err_total, checks_done, nres, seen, seed, i, k;

   fars_top #(.TICK_CYCLES(TK)) DUT (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .excess_current_fault(fin[0]), .bus_high_fault(fin[1]), .bus_low_fault(fin[2]),
      .analog_below_floor_fault(fin[3]), .ext_input_fault_a(fin[4]),
      .ext_input_fault_b(fin[5]), .reset_source_req(reset_source_req),
      .run_enable(run_enable), .fault_reset(fault_reset), .lockout(lockout), .irq(irq));

   // clock
   initial
   begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end

   // monitor: pops the oldest expectation whenever a result is presented
   always @(posedge hclk)
   begin
      if (rd_dp === 1'b1 && hreadyout === 1'b1)
      begin
         exp_w = rq.pop_front();
         `CHK("hrdata", exp_w, hrdata)
         `CHK("hresp", 1'b0, hresp)
      end
      if (pin_dp === 1'b1)
      begin
         exp_w = pq.pop_front();
         `CHK("pins", exp_w, {16'h0, seen[7:0], 5'h0, irq, lockout, run_enable})
      end
      if (fault_reset === 1'b1)
         seen++;
   end

   task automatic conclude;
      if (err_total == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // single ahb-lite word transfer followed by one idle cycle
   task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d,
                       input logic [31:0] e);
      hsel   <= 1'b1;
      haddr  <= {27'h0, a};
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      rd_dp  <= ~w;
      if (!w)
         rq.push_back(e);
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd_dp <= 1'b0;
      hsel  <= 1'b0;
      @(posedge hclk);
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      xfer(1'b1, a, d, 32'h0);
   endtask

   task automatic rd(input logic [4:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0, e);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge hclk);
   endtask

   // notes the expected pin levels and reset count for the next edge
   task automatic obs(input logic r, input logic l, input logic q);
      pq.push_back({16'h0, nres[7:0], 5'h0, q, l, r});
      pin_dp <= 1'b1;
      @(posedge hclk);
      pin_dp <= 1'b0;
      @(posedge hclk);
   endtask

   // fault level held high for a random one or two cycles
   task automatic fpulse(input int f);
      fin[f] <= 1'b1;
      repeat (1 + ($random(seed) & 1)) @(posedge hclk);
      fin[f] <= 1'b0;
      idle(10);
   endtask

   // watchdog
   initial
   begin
      #1000000;
      err_total++;
      conclude();
   end

   // main sequence
   initial
   begin
      {hresetn, hsel, hwrite, reset_source_req, rd_dp, pin_dp} = 6'h0;
      haddr = 32'h0;
      hwdata = 32'h0;
      htrans = 2'b00;
      hsize = 3'b010;
      fin = 6'h0;
      seed = 32'h88c3;
      {err_total, checks_done, nres, seen} = 0;
      idle(10);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(OFS_AR_EN, 32'(RST_AR_EN));
      rd(OFS_MAX_CNT, 32'(RST_MAX_CNT));
      rd(OFS_TRIAL, RST_TRIAL);
      rd(OFS_DELAY, 32'(RST_DELAY));
      rd(OFS_IRQ_MSK, 32'(RST_IRQ_MSK));
      rd(OFS_STATUS, 32'h0);
      obs(1'b1, 1'b0, 1'b0);
      // disabled class holds, uncounted, until panel reset; irq masked then unmasked
      fpulse(0);
      obs(1'b0, 1'b0, 1'b0);
      rd(OFS_STATUS, 32'h0001_0003);
      wr(OFS_MAN_RST, 32'h1);
      nres++;
      rd(OFS_STATUS, 32'h0);
      wr(OFS_IRQ_MSK, 32'h1);
      obs(1'b1, 1'b0, 1'b1);
      wr(OFS_IRQ_STS, 32'h7);
      rd(OFS_IRQ_STS, 32'h0);
      obs(1'b1, 1'b0, 1'b0);
      // each input with only its class enabled, then with only its class disabled
      wr(OFS_DELAY, 32'h0);
      wr(OFS_MAX_CNT, 32'hff);
      for (i = 0; i < 6; i++)
      begin
         k = (i > 4) ? 4 : i;
         wr(OFS_AR_EN, 32'h1 << k);
         fpulse(i);
         nres++;
         obs(1'b1, 1'b0, 1'b1);
         wr(OFS_IRQ_STS, 32'h7);
         wr(OFS_AR_EN, 32'h1f ^ (32'h1 << k));
         fpulse(i);
         obs(1'b0, 1'b0, 1'b1);
         wr(OFS_MAN_RST, 32'h1);
         wr(OFS_IRQ_STS, 32'h7);
         nres++;
         obs(1'b1, 1'b0, 1'b0);
      end
      // three resets allowed, the fourth fault locks out
      wr(OFS_AR_EN, 32'h1f);
      wr(OFS_MAX_CNT, 32'h3);
      wr(OFS_IRQ_MSK, 32'h4);
      for (i = 0; i < 4; i++)
      begin
         fpulse(($random(seed) & 32'h7fff_ffff) % 6);
         if (i < 3)
            nres++;
         if (i == 0)
            rd(OFS_STATUS, 32'h0000_0100);
         obs(i == 3 ? 1'b0 : 1'b1, i == 3, i == 3);
      end
      // source reset refused while a fault is still active, accepted once clear
      fin[1] <= 1'b1;
      @(posedge hclk);
      reset_source_req <= 1'b1;
      @(posedge hclk);
      reset_source_req <= 1'b0;
      idle(3);
      obs(1'b0, 1'b1, 1'b1);
      fin[1] <= 1'b0;
      @(posedge hclk);
      reset_source_req <= 1'b1;
      @(posedge hclk);
      reset_source_req <= 1'b0;
      nres++;
      idle(4);
      obs(1'b1, 1'b0, 1'b1);
      wr(OFS_IRQ_STS, 32'h7);
      // restart delay of five ticks, then analog fault held long
      wr(OFS_TRIAL, 32'd50);
      wr(OFS_DELAY, 32'h5);
      fpulse(0);
      obs(1'b0, 1'b0, 1'b0);
      idle(20);
      nres++;
      obs(1'b1, 1'b0, 1'b0);
      fin[3] <= 1'b1;
      idle(60);
      obs(1'b0, 1'b0, 1'b0);
      fin[3] <= 1'b0;
      idle(3);
      nres++;
      obs(1'b1, 1'b0, 1'b0);
      // window of 50 ticks with a maximum of one reset
      wr(OFS_DELAY, 32'h0);
      wr(OFS_MAX_CNT, 32'h1);
      idle(250);
      fpulse(2);
      nres++;
      obs(1'b1, 1'b0, 1'b0);
      idle(250);
      fpulse(3);
      nres++;
      obs(1'b1, 1'b0, 1'b0);
      fpulse(4);
      obs(1'b0, 1'b1, 1'b1);
      wr(OFS_MAN_RST, 32'h1);
      nres++;
      obs(1'b1, 1'b0, 1'b1);
      conclude();
   end
endmodule // test_fars_top
`default_nettype wire
